/* common/mic_hook_cfg.svh */
// Summary of operation
// - Insertion detection is always debounced
// - Polarity 0 and current present sets flag
// - Ten samples above threshold raise hook flag
// - Ten samples below threshold raise release flag
// - Hook detection is always debounced
// - Pins show steady state, not events
// - Pin changes wait the same detect delays
`ifndef MIC_HOOK_CFG_SVH
`define MIC_HOOK_CFG_SVH

// Register byte offsets, low address byte only
`define REG_CTRL_OFS          8'h00
`define REG_STATUS_OFS        8'h04
`define REG_STATE_OFS         8'h08

// Field positions
`define MIC_BIT               0
`define HOOK_BIT              1

// Reset values
`define CTRL_RESET            2'h0
`define STATUS_RESET          2'h0
`define STATE_RESET           2'h0

// Consecutive qualifying samples before a detection
`define INSERT_DETECT_SAMPLES 4'h8
`define HOOK_DETECT_SAMPLES   4'hA

// AHB-Lite encodings
`define HTRANS_NONSEQ_BIT     1
`define HRESP_OKAY            1'h0

`endif

/* common/mic_hook_pkg.sv */
`default_nettype none
package mic_hook_pkg;

  // One bias current comparator sample
  typedef struct packed {
    logic valid;       // Sample strobe
    logic above_mic;   // Above mic present threshold
    logic above_hook;  // Above hook threshold
  } sense_s;

  // AHB-Lite request signals from the master
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_s;

  // Qualifier instance roles
  typedef enum logic [3:0] {
    Q_MIC_IRQ   = 4'b0001,
    Q_HOOK_IRQ  = 4'b0010,
    Q_MIC_PIN   = 4'b0100,
    Q_HOOK_PIN  = 4'b1000
  } qual_role_e;

endpackage
`default_nettype wire

/* design/run_qualifier.sv */
`default_nettype none
module run_qualifier (
  input  wire logic       clk,          // Core clock
  input  wire logic       rst_b,        // Async reset, active low
  input  wire logic       sample_valid, // Sample strobe
  input  wire logic       sample_level, // Comparator level
  input  wire logic       target,       // Level being sought
  input  wire logic [3:0] limit,        // Run length to qualify
  output logic            hit           // One-cycle pulse on qualification
);

  logic [3:0] count;
  logic       target_q;
  logic       restart;
  logic       match;
  logic       fire;

  ////////////////////////////////////////////////////////////////
  // A target change discards any run built for the old target
  assign restart = target != target_q;
  assign match   = sample_level == target;
  assign fire    = sample_valid && match && !restart && (count == limit - 4'h1);

  // Run counter saturates at limit, so one hit per run
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 4'h0;
    end else if (restart) begin
      count <= 4'h0;
    end else if (sample_valid) begin
      if (!match) begin
        count <= 4'h0;
      end else if (count != limit) begin
        count <= count + 4'h1;
      end
    end
  end

  // Target tracking for the restart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      target_q <= 1'b0;
    end else begin
      target_q <= target;
    end
  end

  // Registered qualification pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit <= 1'b0;
    end else begin
      hit <= fire;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  a_restart_on_miss: assert property (@(posedge clk) disable iff (!rst_b)
    sample_valid && !match |=> count == 4'h0)
    else $error("run counter kept counting after a failed sample");

  a_hit_full_run: assert property (@(posedge clk) disable iff (!rst_b)
    hit |-> $past(count) == limit - 4'h1 && $past(sample_valid && match))
    else $error("hit without a complete run");

  a_count_bounded: assert property (@(posedge clk) disable iff (!rst_b)
    count <= limit)
    else $error("run counter above its limit");

endmodule
`default_nettype wire

/* design/mic_hook_detect.sv */
// Design decisions made here: the register offsets and register access over AHB-Lite.
`default_nettype none
`include "mic_hook_cfg.svh"
module mic_hook_detect (
  input  wire logic                  CORE_CLK,          // 200 MHz core clock
  input  wire logic                  RST_B,             // Async reset, active low
  input  wire mic_hook_pkg::sense_s  SENSE,             // Bias current comparator samples
  input  wire mic_hook_pkg::ahb_req_s AHB_REQ,          // AHB-Lite request
  output logic [31:0]                HRDATA,            // AHB-Lite read data
  output logic                       HREADYOUT,         // AHB-Lite ready
  output logic                       HRESP,             // AHB-Lite response
  output logic                       MIC_PRESENT_PIN,   // Steady mic present state
  output logic                       HOOK_PRESSED_PIN   // Steady hook pressed state
);
  import mic_hook_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Control and status state
  logic       mic_present_polarity;
  logic       hook_press_polarity;
  logic       mic_present_flag;
  logic       hook_press_flag;
  logic       mic_state;
  logic       hook_state;
  logic [3:0] qual_hit;
  logic [3:0] qual_level;
  logic [3:0] qual_target;
  logic [3:0] qual_limit [4];

  // Bus data phase tracking
  logic       dp_write;
  logic [7:0] dp_addr;
  logic       take;
  logic       wr_ctrl;
  logic       wr_status;
  logic       clr_mic;
  logic       clr_hook;
  logic [31:0] next_rdata;

  ////////////////////////////////////////////////////////////////
  // Qualifier inputs: two event detectors steered by polarity,
  // two steady-state trackers seeking the opposite of their state
  assign qual_level[0]  = SENSE.above_mic;
  assign qual_level[1]  = SENSE.above_hook;
  assign qual_level[2]  = SENSE.above_mic;
  assign qual_level[3]  = SENSE.above_hook;
  assign qual_target[0] = ~mic_present_polarity;
  assign qual_target[1] = ~hook_press_polarity;
  assign qual_target[2] = ~mic_state;
  assign qual_target[3] = ~hook_state;
  assign qual_limit[0]  = `INSERT_DETECT_SAMPLES;
  assign qual_limit[1]  = `HOOK_DETECT_SAMPLES;
  assign qual_limit[2]  = `INSERT_DETECT_SAMPLES;
  assign qual_limit[3]  = `HOOK_DETECT_SAMPLES;

  // Debounce is always on; there is no bypass by design
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_qual
      run_qualifier u_qual (
        .clk          (CORE_CLK),
        .rst_b        (RST_B),
        .sample_valid (SENSE.valid),
        .sample_level (qual_level[gi]),
        .target       (qual_target[gi]),
        .limit        (qual_limit[gi]),
        .hit          (qual_hit[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Bus decode; zero wait states so hready alone gates the phase
  assign take      = AHB_REQ.hsel && AHB_REQ.htrans[`HTRANS_NONSEQ_BIT] && AHB_REQ.hready;
  assign wr_ctrl   = dp_write && AHB_REQ.hready && (dp_addr == `REG_CTRL_OFS);
  assign wr_status = dp_write && AHB_REQ.hready && (dp_addr == `REG_STATUS_OFS);
  assign clr_mic   = wr_status && AHB_REQ.hwdata[`MIC_BIT];
  assign clr_hook  = wr_status && AHB_REQ.hwdata[`HOOK_BIT];

  // Address phase capture
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (AHB_REQ.hready) begin
      dp_write <= take && AHB_REQ.hwrite;
      dp_addr  <= AHB_REQ.haddr[7:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (AHB_REQ.haddr[7:0])
      `REG_CTRL_OFS: begin
        next_rdata[`MIC_BIT]  = mic_present_polarity;
        next_rdata[`HOOK_BIT] = hook_press_polarity;
      end
      `REG_STATUS_OFS: begin
        next_rdata[`MIC_BIT]  = mic_present_flag;
        next_rdata[`HOOK_BIT] = hook_press_flag;
      end
      `REG_STATE_OFS: begin
        next_rdata[`MIC_BIT]  = mic_state;
        next_rdata[`HOOK_BIT] = hook_state;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data sampled at the address phase, held otherwise
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      HRDATA <= 32'h0000_0000;
    end else if (take && !AHB_REQ.hwrite) begin
      HRDATA <= next_rdata;
    end
  end

  // Never stalls and never errors
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      HREADYOUT <= 1'b1;
      HRESP     <= `HRESP_OKAY;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= `HRESP_OKAY;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Polarity control, software owned
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {hook_press_polarity, mic_present_polarity} <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      mic_present_polarity <= AHB_REQ.hwdata[`MIC_BIT];
      hook_press_polarity  <= AHB_REQ.hwdata[`HOOK_BIT];
    end
  end

  // Sticky mic flag, write one to clear; a new event beats the clear
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mic_present_flag <= 1'b0;
    end else if (qual_hit[0]) begin
      mic_present_flag <= 1'b1;
    end else if (clr_mic) begin
      mic_present_flag <= 1'b0;
    end
  end

  // Sticky hook flag, same clearing scheme
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      hook_press_flag <= 1'b0;
    end else if (qual_hit[1]) begin
      hook_press_flag <= 1'b1;
    end else if (clr_hook) begin
      hook_press_flag <= 1'b0;
    end
  end

  // Steady states flip only after a full qualifying run
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {hook_state, mic_state} <= `STATE_RESET;
    end else begin
      if (qual_hit[2]) begin
        mic_state <= ~mic_state;
      end
      if (qual_hit[3]) begin
        hook_state <= ~hook_state;
      end
    end
  end

  // Pins mirror the steady state one cycle later
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MIC_PRESENT_PIN  <= 1'b0;
      HOOK_PRESSED_PIN <= 1'b0;
    end else begin
      MIC_PRESENT_PIN  <= mic_state;
      HOOK_PRESSED_PIN <= hook_state;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  a_mic_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    mic_present_flag && !clr_mic |=> mic_present_flag)
    else $error("mic flag dropped without a clear");

  a_hook_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    hook_press_flag && !clr_hook |=> hook_press_flag)
    else $error("hook flag dropped without a clear");

  a_mic_flag_cause: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    $rose(mic_present_flag) |-> $past(qual_hit[0]))
    else $error("mic flag set without a qualified run");

  a_hook_flag_cause: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    $rose(hook_press_flag) |-> $past(qual_hit[1]))
    else $error("hook flag set without a qualified run");

  a_set_beats_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    qual_hit[1] && clr_hook |=> hook_press_flag)
    else $error("hook event lost to a simultaneous clear");

  a_pin_delay: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    $changed(MIC_PRESENT_PIN) |-> $past(qual_hit[2], 2))
    else $error("mic pin changed without a qualified run");

  a_pin_steady: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    ##1 HOOK_PRESSED_PIN == $past(hook_state))
    else $error("hook pin does not follow steady state");

  a_ctrl_write: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    wr_ctrl |=> hook_press_polarity == $past(AHB_REQ.hwdata[`HOOK_BIT]))
    else $error("hook polarity write not applied");

  c_mic_insert: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
    !mic_present_polarity && $rose(mic_present_flag));
  c_hook_release: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
    hook_press_polarity && $rose(hook_press_flag));
  c_clear_race: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
    qual_hit[0] && clr_mic);
  c_pin_rise: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
    $rose(HOOK_PRESSED_PIN));

endmodule
`default_nettype wire

/* testbench/ahb_host_model.sv */
`default_nettype none
module ahb_host_model (
  input  wire logic                   clk,   // Core clock
  input  wire logic                   ready, // Slave ready
  input  wire logic [31:0]            rdata, // Slave read data
  output var  mic_hook_pkg::ahb_req_s req    // Request to slave
);
  timeunit 1ns;
  timeprecision 100ps;
  import mic_hook_pkg::*;

  ahb_req_s q;

  ////////////////////////////////////////////////////////////
  // Bus hready is the one slave's ready, no other slaves
  always_comb begin
    req        = q;
    req.hready = ready;
  end

  initial q = '0;

  ////////////////////////////////////////////////////////////
  // One single word transfer; no latency is assumed, ready decides
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    q.hsel   <= 1'h1;
    q.haddr  <= {24'h0, a};
    q.htrans <= 2'h2;
    q.hwrite <= w;
    q.hsize  <= 3'h2;
    do @(posedge clk); while (ready !== 1'h1);
    q.hsel   <= 1'h0;
    q.htrans <= 2'h0;
    q.hwdata <= d;
    do @(posedge clk); while (ready !== 1'h1);
    r = rdata;
  endtask
endmodule
`default_nettype wire

/* testbench/mic_hook_detect_irq_bench.sv */
`default_nettype none
`include "mic_hook_cfg.svh"
module mic_hook_detect_irq_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mic_hook_pkg::*;

  logic        clk;
  logic        rst_b;
  sense_s      sense;
  ahb_req_s    req;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        mic_pin;
  logic        hook_pin;
  logic [31:0] rd;
  int          error_cnt;
  int          checks;

  mic_hook_detect mic_hook_detect_i (
    .CORE_CLK(clk), .RST_B(rst_b), .SENSE(sense), .AHB_REQ(req), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .MIC_PRESENT_PIN(mic_pin), .HOOK_PRESSED_PIN(hook_pin));

  ahb_host_model ahb_host_model_i (.clk(clk), .ready(hreadyout), .rdata(hrdata), .req(req));

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////
  // Expected register image, mic in one bit, hook in the other
  function automatic logic [31:0] img(input logic m, input logic h);
    img            = '0;
    img[`MIC_BIT]  = m;
    img[`HOOK_BIT] = h;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb_host_model_i.xfer(1'h0, a, 32'h0, rd);
    chk(rd, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb_host_model_i.xfer(1'h1, a, d, rd);
  endtask

  // Steady state seen both in the register and on the pins
  task automatic st(input logic m, input logic h);
    rchk(`REG_STATE_OFS, img(m, h));
    chk({30'h0, hook_pin, mic_pin}, img(m, h));
  endtask

  // Valid samples at fixed levels; random idle gaps must not break a run
  task automatic run(input logic m, input logic h, input int n);
    repeat (n) begin
      sense <= '{1'h1, m, h};
      @(posedge clk);
      if ($urandom_range(0, 3) == 0) begin
        sense.valid <= 1'h0;
        @(posedge clk);
      end
    end
    sense.valid <= 1'h0;
    repeat (3) @(posedge clk);
  endtask

  // Bursts one short of qualifying at most, each cut by one miss
  task automatic bounce(input logic hook, input int lim);
    for (int i = 0; i < 6; i++) begin
      run(1'h1, hook, i == 5 ? lim : $urandom_range(1, lim));
      run(hook, 1'h0, 1);
    end
  endtask

  task automatic stop_test;
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    error_cnt++;
    stop_test;
  end

  initial begin
    clk       = 1'h0;
    rst_b     = 1'h0;
    sense     = '0;
    error_cnt = 0;
    checks    = 0;
    void'($urandom(32'hCDEB));
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    // Reset images, access kinds, unmapped place
    rchk(`REG_CTRL_OFS, 32'h0);
    rchk(`REG_STATUS_OFS, 32'h0);
    st(1'h0, 1'h0);
    wr(`REG_STATE_OFS, 32'h3);
    rchk(`REG_STATE_OFS, 32'h0);
    rchk(8'h0C, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hreadyout}, 32'h1);
    wr(`REG_CTRL_OFS, 32'h3);
    rchk(`REG_CTRL_OFS, 32'h3);
    wr(`REG_CTRL_OFS, 32'h0);
    // Insertion with jack bounce, then a full run
    bounce(1'h0, 7);
    rchk(`REG_STATUS_OFS, img(1'h0, 1'h0));
    st(1'h0, 1'h0);
    run(1'h1, 1'h0, 8);
    rchk(`REG_STATUS_OFS, img(1'h1, 1'h0));
    st(1'h1, 1'h0);
    wr(`REG_CTRL_OFS, img(1'h1, 1'h0));
    wr(`REG_STATUS_OFS, img(1'h1, 1'h0));
    rchk(`REG_STATUS_OFS, img(1'h0, 1'h0));
    // Hook press: nine-sample bursts stay quiet, ten raise the flag
    bounce(1'h1, 9);
    rchk(`REG_STATUS_OFS, img(1'h0, 1'h0));
    run(1'h1, 1'h1, 10);
    rchk(`REG_STATUS_OFS, img(1'h0, 1'h1));
    run(1'h1, 1'h0, 3);
    rchk(`REG_STATUS_OFS, img(1'h0, 1'h1));
    st(1'h1, 1'h1);
    wr(`REG_CTRL_OFS, img(1'h1, 1'h1));
    wr(`REG_STATUS_OFS, img(1'h0, 1'h1));
    // Release: ten samples below threshold are needed, so nine do not suffice
    run(1'h1, 1'h0, 9);
    rchk(`REG_STATUS_OFS, img(1'h0, 1'h0));
    run(1'h1, 1'h0, 1);
    rchk(`REG_STATUS_OFS, img(1'h0, 1'h1));
    st(1'h1, 1'h0);
    wr(`REG_CTRL_OFS, img(1'h1, 1'h0));
    wr(`REG_STATUS_OFS, img(1'h0, 1'h1));
    // Removal
    run(1'h0, 1'h0, 8);
    rchk(`REG_STATUS_OFS, img(1'h1, 1'h0));
    wr(`REG_CTRL_OFS, 32'h0);
    wr(`REG_STATUS_OFS, img(1'h1, 1'h0));
    rchk(`REG_STATUS_OFS, 32'h0);
    st(1'h0, 1'h0);
    stop_test;
  end
endmodule
`default_nettype wire
